/* hw/vuf_fault_map.vh */
`ifndef VUF_FAULT_MAP_VH
`define VUF_FAULT_MAP_VH

// Command codes
`define VUF_CMD_UV_WARN 8'h43
`define VUF_CMD_UV_ACTION 8'h45
`define VUF_CMD_OC_LIMIT 8'h46

// Reset values
`define VUF_RST_UV_WARN 16'h0067
`define VUF_RST_UV_ACTION 8'h40
`define VUF_RST_OC_LIMIT 16'h081E

// Response byte fields
`define VUF_ACT_HI 7
`define VUF_ACT_LO 6
`define VUF_RETRY_HI 5
`define VUF_RETRY_LO 3
`define VUF_DLY_HI 1
`define VUF_DLY_LO 0
`define VUF_ACT_CONTINUE 2'h0
`define VUF_ACT_DELAYED 2'h1
`define VUF_RETRY_LATCH 3'h0
`define VUF_RETRY_HICCUP 3'h7

// Peak limit fields
`define VUF_EXP_HI 15
`define VUF_EXP_LO 11
`define VUF_MANT_HI 10
`define VUF_MANT_LO 0
`define VUF_OC_EXP 5'h01
`define VUF_OC_MANT_MIN 11'h001
`define VUF_OC_MANT_MAX 11'h01F

// Limit-percentage command field for the under-voltage level
`define VUF_PCT_UV_HI 5
`define VUF_PCT_UV_LO 3

// Status bit positions
`define VUF_SV_UV_WARN 6
`define VUF_SV_UV_FAULT 4
`define VUF_SI_OC_PEAK 7
`define VUF_SC_INVALID 6
`define VUF_SW_VOUT 15
`define VUF_SW_IOUT 14

// Timing
`define VUF_CLK_NS 100
`define VUF_DLY0_NS 6250
`define VUF_DLY1_NS 7500
`define VUF_DLY2_NS 8750
`define VUF_DLY3_NS 10000
`define VUF_HICCUP_MS 1000

`endif

/* hw/vuf_pin_sync.v */
`timescale 1ns/1ns
module vuf_pin_sync #(
  parameter W = 2
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  input wire clk_en_in,
  // Pins
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level_out
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  reg [W-1:0] level;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // Stage one feeds stage two only; a change counts once two and three agree
      always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          level[i] <= 1'b0;
        end else if (clk_en_in) begin
          s1[i] <= pin_in[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            level[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

  assign level_out = level;
endmodule

/* hw/vuf_resp_timer.v */
`timescale 1ns/1ns
`include "vuf_fault_map.vh"
module vuf_resp_timer (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  input wire clk_en_in,
  // Fault and policy
  input wire fault_in,
  input wire [1:0] action_in,
  input wire [2:0] retry_in,
  input wire [1:0] dly_sel_in,
  input wire [23:0] hiccup_cycles_in,
  // Control
  input wire clear_in,
  input wire run_cmd_in,
  input wire shutdown_in,
  output reg power_on_out
);
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_DELAY = 2'h1;
  localparam [1:0] ST_LATCH = 2'h2;
  localparam [1:0] ST_HICCUP = 2'h3;

  // Least times round up to whole cycles
  localparam integer DLY0_N = (`VUF_DLY0_NS + `VUF_CLK_NS - 1) / `VUF_CLK_NS;
  localparam integer DLY1_N = (`VUF_DLY1_NS + `VUF_CLK_NS - 1) / `VUF_CLK_NS;
  localparam integer DLY2_N = (`VUF_DLY2_NS + `VUF_CLK_NS - 1) / `VUF_CLK_NS;
  localparam integer DLY3_N = (`VUF_DLY3_NS + `VUF_CLK_NS - 1) / `VUF_CLK_NS;
  localparam [23:0] DLY0 = DLY0_N[23:0];
  localparam [23:0] DLY1 = DLY1_N[23:0];
  localparam [23:0] DLY2 = DLY2_N[23:0];
  localparam [23:0] DLY3 = DLY3_N[23:0];

  reg [1:0] state;
  reg [23:0] cnt;
  reg [1:0] next_state;
  reg [23:0] next_cnt;
  reg [23:0] dly_cycles;

  always @* begin
    case (dly_sel_in)
      2'h0: dly_cycles = DLY0;
      2'h1: dly_cycles = DLY1;
      2'h2: dly_cycles = DLY2;
      default: dly_cycles = DLY3;
    endcase
  end

  always @* begin
    next_state = state;
    next_cnt = cnt;
    if (!run_cmd_in || shutdown_in) begin
      // Commanded off or shut by another fault: stop and drop any retry
      next_state = ST_RUN;
      next_cnt = 24'h000000;
    end else begin
      case (state)
        ST_RUN: begin
          if (fault_in && action_in == `VUF_ACT_DELAYED) begin
            next_state = ST_DELAY;
            next_cnt = dly_cycles - 24'h000001;
          end
        end
        ST_DELAY: begin
          if (!fault_in) begin
            next_state = ST_RUN;
          end else if (cnt == 24'h000000) begin
            if (retry_in == `VUF_RETRY_HICCUP) begin
              next_state = ST_HICCUP;
              next_cnt = hiccup_cycles_in - 24'h000001;
            end else begin
              next_state = ST_LATCH;
            end
          end else begin
            next_cnt = cnt - 24'h000001;
          end
        end
        ST_LATCH: begin
          if (clear_in) begin
            next_state = ST_RUN;
          end
        end
        ST_HICCUP: begin
          if (cnt == 24'h000000) begin
            next_state = ST_RUN;
          end else begin
            next_cnt = cnt - 24'h000001;
          end
        end
        default: next_state = ST_RUN;
      endcase
    end
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_RUN;
      cnt <= 24'h000000;
      power_on_out <= 1'b0;
    end else if (clk_en_in) begin
      state <= next_state;
      cnt <= next_cnt;
      // Continue mode never reaches the off states
      power_on_out <= run_cmd_in && !shutdown_in &&
        (next_state == ST_RUN || next_state == ST_DELAY);
    end
  end
endmodule

/* hw/vuf_fault_cmds.v */
`timescale 1ns/1ns
`include "vuf_fault_map.vh"
// Operation
// - Hold 16-bit unsigned under-voltage warning threshold
// - Output below warning sets status bit six
// - Fault level comes from percentage bits 5:3
// - Under-voltage fault sets word, vout bits, alert
// - Fault bits stay set until cleared
// - Store-all snapshots these commands to nonvolatile
// - Response byte resets to 40 hex
// - Action 00 keeps converting during fault
// - Action 01 waits delay, then applies retry
// - Actions 10 and 11 flag invalid data
// - Retry 000 latches off until cleared
// - Retry 111 hiccups every second until stopped
// - Retry 001 to 110 flag invalid data
// - Delay bits 1:0 pick 6.25 to 10 us
// - High-side current at limit raises peak fault
// - Peak limit exponent fixed at one
// - Peak codes 0801 to 081F only, reset 081E
// - Unsupported encodings flag invalid on response and peak-limit commands only
module vuf_fault_cmds #(
  parameter HICCUP_CYCLES = `VUF_HICCUP_MS * 1000000 / `VUF_CLK_NS
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  input wire clk_en_in,
  // Command port
  input wire [7:0] cmd_code_in,
  input wire [15:0] cmd_wdata_in,
  input wire cmd_wr_in,
  input wire cmd_rd_in,
  output reg [15:0] rd_data_out,
  output reg rd_valid_out,
  // System control
  input wire clear_faults_in,
  input wire store_all_in,
  input wire run_cmd_in,
  input wire other_fault_off_in,
  input wire [15:0] output_limit_percentage_cmd_in,
  input wire [15:0] vout_code_in,
  // Analog comparator pins
  input wire uv_fault_det_in,
  input wire oc_peak_det_in,
  // Comparator settings
  output reg [2:0] uv_level_sel_out,
  output reg [10:0] iout_peak_limit_code_out,
  // Status
  output reg [7:0] status_vout_out,
  output reg [7:0] status_iout_out,
  output reg [7:0] status_cml_out,
  output reg [15:0] status_word_out,
  output reg host_alert_output_n_out,
  // Power stage
  output wire power_enable_out,
  // Nonvolatile store
  output reg nvm_store_out,
  output reg [39:0] nvm_data_out
);
  // Counter is 24 bits; the one-second default still fits
  localparam integer HICCUP_N = HICCUP_CYCLES;
  localparam [23:0] HICCUP_CNT = HICCUP_N[23:0];

  reg [15:0] vout_under_warn_threshold;
  reg [7:0] vout_under_fault_action;
  reg [15:0] iout_peak_fault_threshold;

  wire [1:0] det_level;
  wire uv_fault;
  wire oc_peak;

  reg action_ok;
  reg limit_ok;
  reg wr_invalid;
  reg [15:0] next_rd_data;

  reg uv_warn_set;
  reg [7:0] next_status_vout;
  reg [7:0] next_status_iout;
  reg [7:0] next_status_cml;

  // Comparators are asynchronous to the core clock
  vuf_pin_sync #(
    .W(2)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .pin_in({oc_peak_det_in, uv_fault_det_in}),
    .level_out(det_level)
  );

  assign uv_fault = det_level[0];
  assign oc_peak = det_level[1];

  vuf_resp_timer u_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .fault_in(uv_fault),
    .action_in(vout_under_fault_action[`VUF_ACT_HI:`VUF_ACT_LO]),
    .retry_in(vout_under_fault_action[`VUF_RETRY_HI:`VUF_RETRY_LO]),
    .dly_sel_in(vout_under_fault_action[`VUF_DLY_HI:`VUF_DLY_LO]),
    .hiccup_cycles_in(HICCUP_CNT),
    .clear_in(clear_faults_in),
    .run_cmd_in(run_cmd_in),
    .shutdown_in(other_fault_off_in),
    .power_on_out(power_enable_out)
  );

  // Encoding checks
  always @* begin
    action_ok = (cmd_wdata_in[`VUF_ACT_HI:`VUF_ACT_LO] == `VUF_ACT_CONTINUE ||
      cmd_wdata_in[`VUF_ACT_HI:`VUF_ACT_LO] == `VUF_ACT_DELAYED) &&
      (cmd_wdata_in[`VUF_RETRY_HI:`VUF_RETRY_LO] == `VUF_RETRY_LATCH ||
      cmd_wdata_in[`VUF_RETRY_HI:`VUF_RETRY_LO] == `VUF_RETRY_HICCUP);
    limit_ok = (cmd_wdata_in[`VUF_EXP_HI:`VUF_EXP_LO] == `VUF_OC_EXP) &&
      (cmd_wdata_in[`VUF_MANT_HI:`VUF_MANT_LO] >= `VUF_OC_MANT_MIN) &&
      (cmd_wdata_in[`VUF_MANT_HI:`VUF_MANT_LO] <= `VUF_OC_MANT_MAX);
    wr_invalid = 1'b0;
    if (cmd_wr_in) begin
      case (cmd_code_in)
        `VUF_CMD_UV_ACTION: wr_invalid = !action_ok;
        `VUF_CMD_OC_LIMIT: wr_invalid = !limit_ok;
        default: wr_invalid = 1'b0;
      endcase
    end
  end

  // Command writes; a rejected value leaves the old one in place
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vout_under_warn_threshold <= `VUF_RST_UV_WARN;
      vout_under_fault_action <= `VUF_RST_UV_ACTION;
      iout_peak_fault_threshold <= `VUF_RST_OC_LIMIT;
    end else if (clk_en_in && cmd_wr_in) begin
      case (cmd_code_in)
        `VUF_CMD_UV_WARN: begin
          vout_under_warn_threshold <= cmd_wdata_in;
        end
        `VUF_CMD_UV_ACTION: begin
          if (action_ok) begin
            vout_under_fault_action <= cmd_wdata_in[7:0];
          end
        end
        `VUF_CMD_OC_LIMIT: begin
          if (limit_ok) begin
            iout_peak_fault_threshold <= cmd_wdata_in;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read path
  always @* begin
    case (cmd_code_in)
      `VUF_CMD_UV_WARN: next_rd_data = vout_under_warn_threshold;
      `VUF_CMD_UV_ACTION: next_rd_data = {8'h00, vout_under_fault_action};
      `VUF_CMD_OC_LIMIT: next_rd_data = iout_peak_fault_threshold;
      default: next_rd_data = 16'h0000;
    endcase
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 16'h0000;
      rd_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      rd_valid_out <= cmd_rd_in;
      if (cmd_rd_in) begin
        rd_data_out <= next_rd_data;
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always @* begin
    uv_warn_set = vout_code_in < vout_under_warn_threshold;
    next_status_vout = clear_faults_in ? 8'h00 : status_vout_out;
    next_status_iout = clear_faults_in ? 8'h00 : status_iout_out;
    next_status_cml = clear_faults_in ? 8'h00 : status_cml_out;
    if (uv_warn_set) begin
      next_status_vout[`VUF_SV_UV_WARN] = 1'b1;
    end
    if (uv_fault) begin
      next_status_vout[`VUF_SV_UV_FAULT] = 1'b1;
    end
    if (oc_peak) begin
      next_status_iout[`VUF_SI_OC_PEAK] = 1'b1;
    end
    if (wr_invalid) begin
      next_status_cml[`VUF_SC_INVALID] = 1'b1;
    end
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_vout_out <= 8'h00;
      status_iout_out <= 8'h00;
      status_cml_out <= 8'h00;
      status_word_out <= 16'h0000;
      host_alert_output_n_out <= 1'b1;
    end else if (clk_en_in) begin
      status_vout_out <= next_status_vout;
      status_iout_out <= next_status_iout;
      status_cml_out <= next_status_cml;
      status_word_out <= 16'h0000;
      status_word_out[`VUF_SW_VOUT] <= |next_status_vout;
      status_word_out[`VUF_SW_IOUT] <= |next_status_iout;
      // Alert follows any sticky bit, so it also holds until cleared
      host_alert_output_n_out <= !(|next_status_vout || |next_status_iout ||
        |next_status_cml);
    end
  end

  // Comparator settings and nonvolatile snapshot
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      uv_level_sel_out <= 3'h0;
      iout_peak_limit_code_out <= 11'h000;
      nvm_store_out <= 1'b0;
      nvm_data_out <= 40'h0000000000;
    end else if (clk_en_in) begin
      uv_level_sel_out <=
        output_limit_percentage_cmd_in[`VUF_PCT_UV_HI:`VUF_PCT_UV_LO];
      iout_peak_limit_code_out <=
        iout_peak_fault_threshold[`VUF_MANT_HI:`VUF_MANT_LO];
      nvm_store_out <= store_all_in;
      if (store_all_in) begin
        nvm_data_out <= {vout_under_warn_threshold, vout_under_fault_action,
          iout_peak_fault_threshold};
      end
    end
  end
endmodule

/* tb/vuf_fault_cmds_properties.sv */
`timescale 1ns/1ns
module vuf_fault_cmds_chk (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  input wire clk_en_in,
  // Command port
  input wire [7:0] cmd_code_in,
  input wire [15:0] cmd_wdata_in,
  input wire cmd_wr_in,
  input wire cmd_rd_in,
  input wire rd_valid_out,
  // Control
  input wire clear_faults_in,
  input wire store_all_in,
  input wire run_cmd_in,
  // Results
  input wire [10:0] iout_peak_limit_code_out,
  input wire [7:0] status_vout_out,
  input wire [7:0] status_iout_out,
  input wire [7:0] status_cml_out,
  input wire [15:0] status_word_out,
  input wire host_alert_output_n_out,
  input wire power_enable_out,
  input wire nvm_store_out
);
  reg [10:0] last_mant;
  wire wr45 = clk_en_in && cmd_wr_in && cmd_code_in == 8'h45;
  wire wr46 = clk_en_in && cmd_wr_in && cmd_code_in == 8'h46;
  wire [10:0] mant = cmd_wdata_in[10:0];
  wire ok46 = cmd_wdata_in[15:11] == 5'h01 && mant >= 11'h001 && mant <= 11'h01F;
  wire bad_retry = cmd_wdata_in[5:3] != 3'h0 && cmd_wdata_in[5:3] != 3'h7;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // Shadow of the last accepted mantissa; the output is checked two cycles after each accepted write only
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_mant <= 11'h01E;
    end else if (wr46 && ok46) begin
      last_mant <= mant;
    end
  end
  sequence s_oc_write;
    wr46 && ok46;
  endsequence
  sequence s_code_shown;
    ##2 iout_peak_limit_code_out == last_mant;
  endsequence
  AST_OC_CODE: assert property (s_oc_write |-> s_code_shown)
    else $error("peak code not applied");
  AST_RD_ANSWER: assert property (clk_en_in && cmd_rd_in |=> rd_valid_out)
    else $error("read not answered");
  AST_ACT_INVALID: assert property (wr45 && cmd_wdata_in[7] |-> ##[1:2] status_cml_out[6])
    else $error("bad action not flagged");
  AST_RETRY_INVALID: assert property (wr45 && bad_retry |-> ##[1:2] status_cml_out[6])
    else $error("bad retry not flagged");
  AST_OC_INVALID: assert property (wr46 && !ok46 |-> ##[1:2] status_cml_out[6])
    else $error("bad peak code not flagged");
  AST_ALERT: assert property (!host_alert_output_n_out ==
    (|{status_vout_out, status_iout_out, status_cml_out})) else $error("alert mismatch");
  AST_WORD: assert property (status_word_out[15] == (|status_vout_out) &&
    status_word_out[14] == (|status_iout_out)) else $error("status word mismatch");
  AST_STICKY: assert property (status_vout_out[4] && !clear_faults_in |=> status_vout_out[4])
    else $error("fault bit dropped");
  AST_STORE: assert property (store_all_in |-> ##[1:2] nvm_store_out)
    else $error("store not issued");
  AST_RUN_OFF: assert property (!run_cmd_in |=> !power_enable_out)
    else $error("power stayed on");
endmodule

bind vuf_fault_cmds vuf_fault_cmds_chk u_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
  .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in), .cmd_wr_in(cmd_wr_in),
  .cmd_rd_in(cmd_rd_in), .rd_valid_out(rd_valid_out), .clear_faults_in(clear_faults_in),
  .store_all_in(store_all_in), .run_cmd_in(run_cmd_in),
  .iout_peak_limit_code_out(iout_peak_limit_code_out), .status_vout_out(status_vout_out),
  .status_iout_out(status_iout_out), .status_cml_out(status_cml_out),
  .status_word_out(status_word_out), .host_alert_output_n_out(host_alert_output_n_out),
  .power_enable_out(power_enable_out), .nvm_store_out(nvm_store_out)
);

/* tb/vuf_host_model.sv */
`timescale 1ns/1ns
module vuf_host_model (
  // Clock
  input wire core_clk_in,
  // Command port
  output logic [7:0] cmd_code_out,
  output logic [15:0] cmd_wdata_out,
  output logic cmd_wr_out,
  output logic cmd_rd_out,
  input wire [15:0] rd_data_in,
  input wire rd_valid_in
);
  initial begin
    cmd_code_out = 8'hFF;
    cmd_wdata_out = 16'hFFFF;
    cmd_wr_out = 1'b0;
    cmd_rd_out = 1'b0;
  end
  // Idle lines carry the inverse, so a stale word is never taken for a fresh one
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge core_clk_in);
    cmd_code_out = c;
    cmd_wdata_out = d;
    cmd_wr_out = 1'b1;
    @(negedge core_clk_in);
    cmd_wr_out = 1'b0;
    cmd_code_out = ~c;
    cmd_wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
    @(negedge core_clk_in);
    cmd_code_out = c;
    cmd_rd_out = 1'b1;
    @(negedge core_clk_in);
    cmd_rd_out = 1'b0;
    cmd_code_out = ~c;
    ok = rd_valid_in;
    d = rd_data_in;
  endtask
endmodule

/* tb/vuf_fault_cmds_tb_top.sv */
`timescale 1ns/1ns
module vuf_fault_cmds_tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clr_in = 1'b0, store_in = 1'b0, run_in = 1'b1, off_in = 1'b0, uv = 1'b0, oc = 1'b0;
  logic [15:0] pct = 16'h0000, vout = 16'hFFFF, got;
  logic ok;
  logic en = 1'b1;
  wire [7:0] code, sv, si, sc;
  wire [15:0] wdata, rdata, sw;
  wire wr, rd, rdv, alert_n, pwr, nvs;
  wire [2:0] lvl;
  wire [10:0] ocode;
  wire [39:0] nvd;
  int n_mismatch = 0, n_compared = 0, cycles = 0;
  // Rows: code, write data, invalid flag expected, read-back expected
  localparam logic [40:0] ROWS [15] = '{
    {8'h45, 16'h0041, 1'b0, 16'h0041}, {8'h45, 16'h0081, 1'b1, 16'h0041},
    {8'h45, 16'h00C1, 1'b1, 16'h0041}, {8'h45, 16'h0049, 1'b1, 16'h0041},
    {8'h45, 16'h0071, 1'b1, 16'h0041}, {8'h45, 16'h007D, 1'b0, 16'h007D},
    {8'h45, 16'h0001, 1'b0, 16'h0001}, {8'h46, 16'h0801, 1'b0, 16'h0801},
    {8'h46, 16'h081F, 1'b0, 16'h081F}, {8'h46, 16'h0820, 1'b1, 16'h081F},
    {8'h46, 16'h0800, 1'b1, 16'h081F}, {8'h46, 16'h101F, 1'b1, 16'h081F},
    {8'h46, 16'h0805, 1'b0, 16'h0805}, {8'h43, 16'h1234, 1'b0, 16'h1234},
    {8'h20, 16'h5555, 1'b0, 16'h0000}};
  always #50 core_clk_in = ~core_clk_in;
  vuf_fault_cmds #(.HICCUP_CYCLES(50)) u_vuf_fault_cmds (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(en), .cmd_code_in(code),
    .cmd_wdata_in(wdata), .cmd_wr_in(wr), .cmd_rd_in(rd), .rd_data_out(rdata),
    .rd_valid_out(rdv), .clear_faults_in(clr_in), .store_all_in(store_in),
    .run_cmd_in(run_in), .other_fault_off_in(off_in), .output_limit_percentage_cmd_in(pct),
    .vout_code_in(vout), .uv_fault_det_in(uv), .oc_peak_det_in(oc), .uv_level_sel_out(lvl),
    .iout_peak_limit_code_out(ocode), .status_vout_out(sv), .status_iout_out(si),
    .status_cml_out(sc), .status_word_out(sw), .host_alert_output_n_out(alert_n),
    .power_enable_out(pwr), .nvm_store_out(nvs), .nvm_data_out(nvd));
  vuf_host_model u_host (.core_clk_in(core_clk_in), .cmd_code_out(code),
    .cmd_wdata_out(wdata), .cmd_wr_out(wr), .cmd_rd_out(rd), .rd_data_in(rdata),
    .rd_valid_in(rdv));
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic clr;
    @(negedge core_clk_in);
    clr_in = 1'b1;
    @(negedge core_clk_in);
    clr_in = 1'b0;
  endtask
  task automatic wait_pwr(input logic v, input int max);
    for (int i = 0; i < max && pwr !== v; i++) @(negedge core_clk_in);
    chk(40'(pwr), 40'(v));
  endtask
  task automatic complete_run;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    cyc(2);
    rst_in = 1'b0;
    u_host.rd(8'h43, got, ok);
    chk(40'(got), 40'h0067);
    u_host.rd(8'h45, got, ok);
    chk(40'(got), 40'h0040);
    u_host.rd(8'h46, got, ok);
    chk(40'({got, 5'h00, ocode}), 40'h081E001E);
    foreach (ROWS[i]) begin
      clr();
      u_host.wr(ROWS[i][40:33], ROWS[i][32:17]);
      u_host.rd(ROWS[i][40:33], got, ok);
      chk(40'(sc[6]), 40'(ROWS[i][16]));
      chk(40'(got), 40'(ROWS[i][15:0]));
    end
    @(negedge core_clk_in);
    store_in = 1'b1;
    @(negedge core_clk_in);
    store_in = 1'b0;
    chk({nvd[39:1], nvs}, 40'h1234010805);
    vout = 16'h1234;
    cyc(3);
    chk(40'(sv[6]), 40'h0);
    vout = 16'h1233;
    pct = 16'h0028;
    cyc(2);
    chk(40'({sv[6], lvl}), 40'hD);
    oc = 1'b1;
    cyc(6);
    chk(40'({sw[14], si[7]}), 40'h3);
    vout = 16'hFFFF;
    oc = 1'b0;
    run_in = 1'b0;
    cyc(1);
    chk(40'(pwr), 40'h0);
    run_in = 1'b1;
    wait_pwr(1'b1, 3);
    off_in = 1'b1;
    cyc(1);
    chk(40'(pwr), 40'h0);
    off_in = 1'b0;
    wait_pwr(1'b1, 3);
    u_host.wr(8'h45, 16'h0000);
    clr();
    uv = 1'b1;
    cyc(150);
    chk(40'({pwr, sv[4], alert_n}), 40'h6);
    uv = 1'b0;
    u_host.wr(8'h45, 16'h0040);
    clr();
    uv = 1'b1;
    cyc(62);
    chk(40'(pwr), 40'h1);
    wait_pwr(1'b0, 20);
    uv = 1'b0;
    cyc(20);
    chk(40'({pwr, sv[4]}), 40'h1);
    clr();
    wait_pwr(1'b1, 4);
    chk(40'(sv), 40'h0);
    // Delay 3 is 100 cycles; 70-cycle bursts must never trip it if the timer restarts
    u_host.wr(8'h45, 16'h0043);
    repeat (3) begin
      uv = 1'b1;
      cyc(70);
      uv = 1'b0;
      cyc(8);
    end
    chk(40'(pwr), 40'h1);
    u_host.wr(8'h45, 16'h0078);
    uv = 1'b1;
    wait_pwr(1'b0, 80);
    wait_pwr(1'b1, 60);
    uv = 1'b0;
    // A write while the clock enable is low must not land
    en = 1'b0;
    u_host.wr(8'h43, 16'h0001);
    en = 1'b1;
    u_host.rd(8'h43, got, ok);
    chk(40'(got), 40'h1234);
    // Reset in mid-run brings back the defaults
    @(negedge core_clk_in);
    rst_in = 1'b1;
    cyc(2);
    chk(40'({sv, pwr}), 40'h0);
    rst_in = 1'b0;
    u_host.rd(8'h45, got, ok);
    chk(40'({got, ok}), 40'h00081);
    complete_run;
  end
endmodule
